// *** adcsc_top.sv ***
// Conversion sequencing, sync gating, calibration and port pins of a
// multichannel sigma-delta converter, with a Wishbone register file.
// Assumes the modulator delivers a result (or a finished calibration
// coefficient) on MOD_RAW when the conversion time has elapsed.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps

module adcsc_top (
  input  wire logic                        CLK,
  input  wire logic                        RESET_N,
  input  wire logic                        CE,
  input  wire logic                        WB_CYC_I,
  input  wire logic                        WB_STB_I,
  input  wire logic                        WB_WE_I,
  input  wire logic [adcsc_pkg::ADDR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]                  WB_SEL_I,
  input  wire logic [adcsc_pkg::DATA_W-1:0] WB_DAT_I,
  output logic      [adcsc_pkg::DATA_W-1:0] WB_DAT_O,
  output logic                             WB_ACK_O,
  output logic                             PORT_PIN_ZERO_O,
  output logic                             PORT_PIN_ZERO_OE_N,
  input  wire logic                        SYNC_OR_PORT_PIN_ONE_I,
  output logic                             SYNC_OR_PORT_PIN_ONE_O,
  output logic                             SYNC_OR_PORT_PIN_ONE_OE_N,
  input  wire logic [23:0]                 MOD_RAW,
  output logic                             MOD_START,
  output logic      [2:0]                  MOD_CHAN,
  output logic      [2:0]                  MOD_RANGE,
  output logic                             MOD_SHORT,
  output logic                             MOD_FULL_REF
);
  import adcsc_pkg::*;

  // Byte-lane merge of a bus write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (sel[i]) m[8*i +: 8] = nw[8*i +: 8];
    return m;
  endfunction

  adcsc_scale_if sif ();

  adcsc_state_type   state_r;
  adcsc_state_type   state_nxt;
  logic [2:0]        mode_r;
  logic [IO_W-1:0]   io_r;
  logic [NCH-1:0]    rdy_r;
  logic [23:0]       data_r;
  logic [23:0]       adc_zs_r;
  logic [23:0]       adc_fs_r;
  logic [2:0]        chsel_r;
  logic [2:0]        rng_r   [NCH];
  logic [7:0]        ct_r    [NCH];
  logic [22:0]       ch_zs_r [NCH];
  logic [23:0]       ch_fs_r [NCH];
  logic [CNT_W-1:0]  cnt_r;
  logic [2:0]        cur_ch_r;
  logic [2:0]        cur_mode_r;
  logic [23:0]       raw_r;
  logic              sc_start_r;
  logic              sync_low_r;
  logic              ack_r;
  logic [31:0]       dat_r;
  logic              start_r;
  logic              p0_o_r;
  logic              p0_oe_n_r;
  logic              p1_o_r;
  logic              p1_oe_n_r;
  logic              short_r;
  logic              fref_r;
  logic [2:0]        mrange_r;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic        hit;
  logic        wr;
  logic        idle;
  logic        wr_mode;
  logic        wr_cal_ok;
  logic [31:0] rd_data;
  logic [31:0] wdat;
  assign hit       = WB_CYC_I & WB_STB_I & ~ack_r;
  assign wr        = hit & WB_WE_I;
  assign idle      = (state_r == ST_IDLE);
  assign wr_mode   = wr & (WB_ADR_I == OFF_MODE);
  assign wr_cal_ok = wr & idle & ~wr_mode;
  assign wdat      = WB_DAT_I;

  // ----------------------------------------------------------------------
  // Sequencer decode
  // ----------------------------------------------------------------------
  logic       sync_en;
  logic       sync_ok;
  logic       is_cal;
  logic       cnt_zero;
  logic [2:0] cur_rng;
  logic [CNT_W-1:0] conv_cyc;
  assign sync_en  = io_r[IO_SYNC_EN];
  // Disabled sync ignores the pin entirely
  assign sync_ok  = ~sync_en | SYNC_OR_PORT_PIN_ONE_I;
  assign is_cal   = cur_mode_r[2];
  assign cnt_zero = (cnt_r == '0);
  assign cur_rng  = rng_r[cur_ch_r];
  // A zero time setting still gives one unit rather than a stall
  assign conv_cyc = CNT_W'(((ct_r[chsel_r] == 8'h00) ? 1 : ct_r[chsel_r])
                           * CONV_UNIT_CYC - 1);

  // Next-state selection
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (mode_r != MODE_IDLE) state_nxt = ST_WAIT;
      ST_WAIT:  if (sync_ok) state_nxt = ST_CONV;
      ST_CONV:  if (sync_ok && cnt_zero)
                  state_nxt = is_cal ? ST_IDLE : ST_SCALE;
      ST_SCALE: if (sif.done)
                  state_nxt = (cur_mode_r == MODE_CONT) ? ST_WAIT : ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
    // A mode write aborts whatever runs and restarts from idle
    if (wr_mode) state_nxt = ST_IDLE;
  end

  // Read selection
  always_comb begin
    rd_data = 32'h00000000;
    case (WB_ADR_I)
      OFF_MODE:   rd_data = {29'h0, mode_r};
      OFF_IO:     rd_data = {25'h0, sync_low_r, SYNC_OR_PORT_PIN_ONE_I, io_r};
      OFF_STATUS: rd_data = {22'h0, ~sync_ok, ~idle, rdy_r};
      OFF_DATA:   rd_data = {8'h0, data_r};
      OFF_ADC_ZS: rd_data = {8'h0, adc_zs_r};
      OFF_ADC_FS: rd_data = {8'h0, adc_fs_r};
      OFF_CHSEL:  rd_data = {29'h0, chsel_r};
      OFF_CHSET:  rd_data = {16'h0, ct_r[chsel_r], 5'h0, rng_r[chsel_r]};
      OFF_CH_ZS:  rd_data = {9'h0, ch_zs_r[chsel_r]};
      OFF_CH_FS:  rd_data = {8'h0, ch_fs_r[chsel_r]};
      default:    rd_data = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Wishbone answer: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else if (CE) begin
      ack_r <= hit;
      if (hit) dat_r <= rd_data;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers written by software
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_r  <= MODE_IDLE;
      io_r    <= '0;
      chsel_r <= 3'h0;
    end else if (CE) begin
      // Finished single conversions and calibrations drop to idle
      if (state_r == ST_CONV && state_nxt == ST_IDLE)
        mode_r <= MODE_IDLE;
      if (state_r == ST_SCALE && sif.done && cur_mode_r == MODE_SINGLE)
        mode_r <= MODE_IDLE;
      if (wr_mode && WB_SEL_I[0]) mode_r <= wdat[2:0];
      if (wr && WB_ADR_I == OFF_IO && WB_SEL_I[0])
        io_r <= wdat[IO_W-1:0];
      if (wr && WB_ADR_I == OFF_CHSEL && WB_SEL_I[0])
        chsel_r <= wdat[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // Calibration and channel setup storage
  // ----------------------------------------------------------------------
  logic cal_end;
  assign cal_end = (state_r == ST_CONV) && sync_ok && cnt_zero && is_cal;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      adc_zs_r <= 24'h000000;
      adc_fs_r <= RST_GAIN;
      for (int i = 0; i < NCH; i++) begin
        rng_r[i]   <= RST_RANGE;
        ct_r[i]    <= RST_CT;
        ch_zs_r[i] <= 23'h000000;
        ch_fs_r[i] <= RST_GAIN;
      end
    end else if (CE) begin
      if (wr_cal_ok) begin
        case (WB_ADR_I)
          OFF_ADC_ZS: adc_zs_r <= 24'(merge({8'h0, adc_zs_r}, wdat,
                                            WB_SEL_I));
          OFF_ADC_FS: adc_fs_r <= 24'(merge({8'h0, adc_fs_r}, wdat,
                                            WB_SEL_I));
          OFF_CHSET: begin
            if (WB_SEL_I[0]) rng_r[chsel_r] <= wdat[2:0];
            if (WB_SEL_I[1]) ct_r[chsel_r]  <= wdat[CHSET_CT_LSB +: 8];
          end
          OFF_CH_ZS: ch_zs_r[chsel_r] <= 23'(merge({9'h0, ch_zs_r[chsel_r]},
                                                   wdat, WB_SEL_I));
          OFF_CH_FS: ch_fs_r[chsel_r] <= 24'(merge({8'h0, ch_fs_r[chsel_r]},
                                                   wdat, WB_SEL_I));
          default: ;
        endcase
      end
      // Calibration result lands in the register its mode targets
      if (cal_end) begin
        case (cur_mode_r)
          MODE_ZS_SELF: adc_zs_r <= MOD_RAW;
          MODE_FS_SELF: adc_fs_r <= MOD_RAW;
          MODE_ZS_SYS:  ch_zs_r[cur_ch_r] <= MOD_RAW[22:0];
          MODE_FS_SYS:  ch_fs_r[cur_ch_r] <= MOD_RAW;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer: sync gating, conversion timing, result capture
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r    <= ST_IDLE;
      cnt_r      <= '0;
      cur_ch_r   <= 3'h0;
      cur_mode_r <= MODE_IDLE;
      raw_r      <= 24'h000000;
      sc_start_r <= 1'b0;
      start_r    <= 1'b0;
    end else if (CE) begin
      state_r    <= state_nxt;
      sc_start_r <= 1'b0;
      start_r    <= 1'b0;
      if (state_r != ST_CONV && state_nxt == ST_CONV) begin
        cnt_r      <= conv_cyc;
        cur_ch_r   <= chsel_r;
        cur_mode_r <= mode_r;
        start_r    <= 1'b1;
      end else if (state_r == ST_CONV && sync_ok && !cnt_zero) begin
        cnt_r <= cnt_r - 1'b1;
      end
      if (state_r == ST_CONV && state_nxt == ST_SCALE) begin
        raw_r      <= MOD_RAW;
        sc_start_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status and data: set beats clear in the same cycle
  // ----------------------------------------------------------------------
  logic [NCH-1:0] rdy_set;
  logic [NCH-1:0] rdy_clr;
  assign rdy_set = cal_end ? {NCH{1'b1}} :
                   (state_r == ST_SCALE && sif.done) ?
                   NCH'(1) << cur_ch_r : '0;
  assign rdy_clr = (wr && WB_ADR_I == OFF_STATUS && WB_SEL_I[0]) ?
                   wdat[NCH-1:0] : '0;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdy_r      <= '0;
      data_r     <= 24'h000000;
      sync_low_r <= 1'b0;
    end else if (CE) begin
      rdy_r <= (rdy_r & ~rdy_clr) | rdy_set;
      if (state_r == ST_SCALE && sif.done) data_r <= sif.result;
      // A finishing calibration still pulls low if a mode write coincides
      if (cal_end && sync_en) sync_low_r <= 1'b1;
      else if (wr_mode) sync_low_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Pins and modulator controls, all registered
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      p0_o_r    <= 1'b0;
      p0_oe_n_r <= 1'b1;
      p1_o_r    <= 1'b0;
      p1_oe_n_r <= 1'b1;
      short_r   <= 1'b0;
      fref_r    <= 1'b0;
      mrange_r  <= RST_RANGE;
    end else if (CE) begin
      p0_o_r    <= io_r[IO_P0_VAL];
      p0_oe_n_r <= ~io_r[IO_P0_DIG];
      // Sync mode makes pin one an input except while pulled low
      p1_o_r    <= ~sync_low_r & io_r[IO_P1_VAL];
      p1_oe_n_r <= ~((~sync_en & io_r[IO_P1_OUT]) | sync_low_r);
      short_r   <= (state_nxt == ST_CONV) &&
                   ((state_r == ST_CONV ? cur_mode_r : mode_r)
                    == MODE_ZS_SELF);
      fref_r    <= (state_nxt == ST_CONV) &&
                   ((state_r == ST_CONV ? cur_mode_r : mode_r)
                    == MODE_FS_SELF);
      mrange_r  <= ((state_r == ST_CONV ? cur_mode_r : mode_r)
                    == MODE_FS_SELF) ? RNG_2P5_UNI
                   : rng_r[state_r == ST_CONV ? cur_ch_r : chsel_r];
    end
  end

  // Scaler hookup uses the channel captured at conversion start
  assign sif.start   = sc_start_r;
  assign sif.bipolar = cur_rng[RNG_BIPOLAR];
  assign sif.r2      = (cur_rng[1:0] == RNG_0P625);
  assign sif.raw     = raw_r;
  assign sif.adc_zs  = adc_zs_r;
  assign sif.adc_fs  = adc_fs_r;
  assign sif.ch_zs   = ch_zs_r[cur_ch_r];
  assign sif.ch_fs   = ch_fs_r[cur_ch_r];

  adcsc_scale u_scale (
    .clk     (CLK),
    .reset_n (RESET_N),
    .ce      (CE),
    .sif     (sif.dp)
  );

  assign WB_DAT_O                  = dat_r;
  assign WB_ACK_O                  = ack_r;
  assign PORT_PIN_ZERO_O           = p0_o_r;
  assign PORT_PIN_ZERO_OE_N        = p0_oe_n_r;
  assign SYNC_OR_PORT_PIN_ONE_O    = p1_o_r;
  assign SYNC_OR_PORT_PIN_ONE_OE_N = p1_oe_n_r;
  assign MOD_START                 = start_r;
  assign MOD_CHAN                  = cur_ch_r;
  assign MOD_RANGE                 = mrange_r;
  assign MOD_SHORT                 = short_r;
  assign MOD_FULL_REF              = fref_r;
endmodule

// *** adcsc_pkg.sv ***
// Constants shared by the converter control block and its scaling datapath.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone register bus.
package adcsc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ       = 25;
  localparam int CONV_UNIT_NS  = 640;  // One step of the conversion time
  localparam int CONV_UNIT_CYC = (CONV_UNIT_NS * CLK_MHZ) / 1000;
  localparam int CNT_W         = 12;

  // ----------------------------------------------------------------------
  // Bus and register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_IO     = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DATA   = 8'h0c;
  localparam logic [7:0] OFF_ADC_ZS = 8'h10;
  localparam logic [7:0] OFF_ADC_FS = 8'h14;
  localparam logic [7:0] OFF_CHSEL  = 8'h18;
  localparam logic [7:0] OFF_CHSET  = 8'h1c;
  localparam logic [7:0] OFF_CH_ZS  = 8'h20;
  localparam logic [7:0] OFF_CH_FS  = 8'h24;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int IO_P0_VAL  = 0;
  localparam int IO_P0_DIG  = 1;
  localparam int IO_P1_VAL  = 2;
  localparam int IO_P1_OUT  = 3;
  localparam int IO_SYNC_EN = 4;
  localparam int IO_W       = 5;
  localparam int CHSET_CT_LSB = 8;   // Range in [2:0], time in [15:8]
  localparam int RNG_BIPOLAR  = 2;   // Range bit 2 set: bipolar

  // ----------------------------------------------------------------------
  // Modes and ranges
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_IDLE    = 3'h0;
  localparam logic [2:0] MODE_CONT    = 3'h1;
  localparam logic [2:0] MODE_SINGLE  = 3'h2;
  localparam logic [2:0] MODE_ZS_SELF = 3'h4;
  localparam logic [2:0] MODE_FS_SELF = 3'h5;
  localparam logic [2:0] MODE_ZS_SYS  = 3'h6;
  localparam logic [2:0] MODE_FS_SYS  = 3'h7;
  localparam logic [1:0] RNG_0P625    = 2'h0;
  localparam logic [2:0] RNG_2P5_UNI  = 3'h2;

  // ----------------------------------------------------------------------
  // Reset values and arithmetic constants
  // ----------------------------------------------------------------------
  localparam logic [2:0]  RST_RANGE  = 3'h6;
  localparam logic [7:0]  RST_CT     = 8'h40;
  localparam logic [23:0] RST_GAIN   = 24'h200000;
  localparam logic [23:0] BI_OFFSET  = 24'h800000;
  localparam logic [23:0] RAW_MAX    = 24'hffffff;
  localparam int          SH_UNI     = 21;  // Divide by 0x20 0000
  localparam int          SH_BI      = 22;  // Divide by 0x40 0000
  localparam int          NCH        = 8;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_WAIT  = 4'h2,
    ST_CONV  = 4'h4,
    ST_SCALE = 4'h8
  } adcsc_state_type;

endpackage

// *** adcsc_scale_if.sv ***
// Carrier between the control block and its scaling datapath.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface adcsc_scale_if;
  logic        start;
  logic        bipolar;
  logic        r2;
  logic [23:0] raw;
  logic [23:0] adc_zs;
  logic [23:0] adc_fs;
  logic [22:0] ch_zs;
  logic [23:0] ch_fs;
  logic        done;
  logic [23:0] result;
  modport ctl (output start, bipolar, r2, raw, adc_zs, adc_fs, ch_zs, ch_fs,
               input done, result);
  modport dp  (input start, bipolar, r2, raw, adc_zs, adc_fs, ch_zs, ch_fs,
               output done, result);
endinterface

// *** adcsc_scale.sv ***
// Two-stage calibration scaling of one raw conversion result.
// Assumes inputs hold steady from start until done.
`timescale 1ns/100ps
module adcsc_scale (
  input wire logic   clk,
  input wire logic   reset_n,
  input wire logic   ce,
  adcsc_scale_if.dp  sif
);
  import adcsc_pkg::*;

  // Multiply by a gain word and divide by a power of two
  function automatic logic signed [63:0] gain_mul(
    input logic signed [63:0] x,
    input logic [23:0]        g,
    input int                 sh);
    logic signed [63:0] p;
    p = x * $signed({40'h0, g});
    return p >>> sh;
  endfunction

  logic signed [63:0] rz;
  logic signed [63:0] t1;
  logic signed [63:0] t2_nxt;
  logic signed [63:0] t2_r;
  logic signed [63:0] cz;
  logic signed [63:0] t4;
  logic [23:0]        res_nxt;
  logic               v1_r;
  logic               done_r;
  logic [23:0]        res_r;

  // ----------------------------------------------------------------------
  // Stage one: converter offset and gain
  // ----------------------------------------------------------------------
  assign rz = sif.r2 ? $signed({39'h0, sif.adc_zs, 1'b0})
                     : $signed({40'h0, sif.adc_zs});
  assign t1 = $signed({40'h0, sif.raw}) - rz;
  assign t2_nxt = sif.bipolar
    ? gain_mul(t1, sif.adc_fs, SH_BI) + $signed({40'h0, BI_OFFSET})
    : gain_mul(t1, sif.adc_fs, SH_UNI);

  // ----------------------------------------------------------------------
  // Stage two: channel offset (sign and magnitude) and channel gain
  // ----------------------------------------------------------------------
  assign cz = sif.ch_zs[22] ? -$signed({42'h0, sif.ch_zs[21:0]})
                            : $signed({42'h0, sif.ch_zs[21:0]});
  assign t4 = gain_mul(t2_r - (sif.r2 ? cz <<< 1 : cz),
                       sif.ch_fs, SH_UNI);
  // Clamp keeps the result inside the data register range
  assign res_nxt = (t4 < 0) ? 24'h000000 :
                   (t4 > $signed({40'h0, RAW_MAX})) ? RAW_MAX : t4[23:0];

  // Pipeline registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t2_r   <= '0;
      v1_r   <= 1'b0;
      done_r <= 1'b0;
      res_r  <= 24'h000000;
    end else if (ce) begin
      v1_r   <= sif.start;
      done_r <= v1_r;
      if (sif.start) t2_r <= t2_nxt;
      if (v1_r) res_r <= res_nxt;
    end
  end

  assign sif.done   = done_r;
  assign sif.result = res_r;
endmodule

// *** adcsc_properties.sv ***
// Port-level checks on the converter control block.
// Assumes it is bound to adcsc_top and sees only its ports.
`timescale 1ns/100ps
module adcsc_chk (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       CE,
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_ACK_O,
  input wire logic       MOD_START,
  input wire logic [2:0] MOD_RANGE,
  input wire logic       MOD_SHORT,
  input wire logic       MOD_FULL_REF
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // A new request and the quiet time after a period start
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && CE;
  endsequence
  sequence s_quiet;
    !MOD_START [*8];
  endsequence
  chk_ack_answer: assert property (s_req |=> WB_ACK_O)
    else $error("no ack after request");
  chk_ack_single: assert property (WB_ACK_O && CE |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_unasked: assert property (!WB_STB_I && CE |=> !WB_ACK_O)
    else $error("ack without request");
  chk_start_pulse: assert property (MOD_START && CE |=> s_quiet)
    else $error("period restarted too soon");
  chk_full_range: assert property (MOD_FULL_REF |-> MOD_RANGE == 3'h2)
    else $error("full-scale cal not on 2.5 V range");
  chk_short_excl: assert property (!(MOD_SHORT && MOD_FULL_REF))
    else $error("shorted inputs during full-scale cal");
  chk_full_hold: assert property ($rose(MOD_FULL_REF) |=> MOD_FULL_REF[*8])
    else $error("full-scale cal cut short");
  chk_short_hold: assert property ($rose(MOD_SHORT) |=> MOD_SHORT[*8])
    else $error("zero-scale cal cut short");
endmodule
bind adcsc_top adcsc_chk u_chk (.CLK(CLK), .RESET_N(RESET_N), .CE(CE),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .MOD_START(MOD_START), .MOD_RANGE(MOD_RANGE), .MOD_SHORT(MOD_SHORT),
  .MOD_FULL_REF(MOD_FULL_REF));

// *** adcsc_mod_model.sv ***
// Behavioural modulator: hands over the bench's next value per period.
// Assumes the bench sets that value before the period starts.
`timescale 1ns/100ps
module adcsc_mod_model (
  input  wire logic        clk,
  input  wire logic        mod_start,
  input  wire logic [23:0] next_val,
  output logic      [23:0] mod_raw
);
  // Value held for the whole period so the capture edge is safe
  always @(posedge clk) begin
    if (mod_start) begin
      mod_raw <= next_val;
    end
  end
endmodule

// *** tb_adc_sync_and_calibration_control.sv ***
// Bench: register file, scaling, sync gating and calibrations.
// Assumes the modulator model and the bound checker.
`timescale 1ns/100ps
module tb_adc_sync_and_calibration_control;
  import adcsc_pkg::*;
  typedef struct packed {logic [7:0] a; logic w; logic [63:0] de;}
    adcsc_row_type;
  logic        clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic        drv = 1'h0, ack, p0, p0_oe_n, p1_o, p1_oe_n, start, shrt, full;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wd = 32'h0, rd, dat_o;
  logic [23:0] nv = 24'h0, raw;
  logic [2:0]  chan, rng;
  wire         p1 = p1_oe_n ? drv : p1_o;
  int          mismatches = 0, n_compared = 0, k;
  adcsc_row_type rows [9] = '{'{OFF_MODE, 1'h0, 64'h0},
    '{OFF_ADC_FS, 1'h0, 64'h200000}, '{OFF_CHSET, 1'h0, 64'h4006},
    '{OFF_CHSET, 1'h1, 64'h0102_00000000}, '{OFF_CHSET, 1'h0, 64'h0102},
    '{OFF_CH_ZS, 1'h1, 64'h10_00000000}, '{OFF_CH_ZS, 1'h0, 64'h10},
    '{8'h40, 1'h0, 64'h0}, '{OFF_IO, 1'h1, 64'h3_00000000}};
  always #20 clk = ~clk;
  adcsc_top dut (.CLK(clk), .RESET_N(rst_n), .CE(1'h1), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(wd), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PORT_PIN_ZERO_O(p0),
    .PORT_PIN_ZERO_OE_N(p0_oe_n), .SYNC_OR_PORT_PIN_ONE_I(p1),
    .SYNC_OR_PORT_PIN_ONE_O(p1_o), .SYNC_OR_PORT_PIN_ONE_OE_N(p1_oe_n),
    .MOD_RAW(raw), .MOD_START(start), .MOD_CHAN(chan), .MOD_RANGE(rng),
    .MOD_SHORT(shrt), .MOD_FULL_REF(full));
  adcsc_mod_model u_mod (.clk(clk), .mod_start(start), .next_val(nv),
    .mod_raw(raw));
  // Verdict, mismatch reporting and bounded waits
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo;
    mismatches++;
    summarize;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Classic cycle; ack and read data are taken at the same rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int j;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wd <= d;
    for (j = 0; j < 20; j++) begin
      @(posedge clk);
      if (ack === 1'h1) break;
    end
    if (j == 20) tmo;
    rd = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic wstart;
    for (k = 0; k < 3000 && start !== 1'h1; k++) @(negedge clk);
    if (k == 3000) tmo;
  endtask
  task automatic wrdy;
    int j;
    for (j = 0; j < 600; j++) begin
      bus(OFF_STATUS, 1'h0, 32'h0);
      if (rd[7:0] !== 8'h00) break;
    end
    if (j == 600) tmo;
  endtask
  // Reset, table rows, then conversion and calibrations
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    chk({p0_oe_n, p1_oe_n, start}, 32'h6);
    foreach (rows[i]) begin
      bus(rows[i].a, rows[i].w, rows[i].de[63:32]);
      if (!rows[i].w) chk(rd, rows[i].de[31:0]);
    end
    @(negedge clk);
    chk({p0_oe_n, p0}, 32'h1);
    nv <= 24'h100000;
    bus(OFF_MODE, 1'h1, 32'h2);
    wrdy;
    bus(OFF_DATA, 1'h0, 32'h0);
    chk(rd, 32'h0ffff0);
    bus(OFF_STATUS, 1'h1, 32'hff);
    bus(OFF_IO, 1'h1, 32'h13);
    nv <= 24'h1fff00;
    bus(OFF_MODE, 1'h1, 32'h5);
    for (k = 0; k < 40 && start !== 1'h1; k++) @(negedge clk);
    chk(k, 32'd40);
    @(posedge clk);
    drv <= 1'h1;
    wstart;
    chk({full, rng}, 32'ha);
    wrdy;
    chk(rd[7:0], 32'hff);
    bus(OFF_ADC_FS, 1'h0, 32'h0);
    chk(rd, 32'h1fff00);
    bus(OFF_MODE, 1'h0, 32'h0);
    chk({rd[2:0], p1_oe_n, p1_o}, 32'h0);
    bus(OFF_STATUS, 1'h1, 32'hff);
    bus(OFF_IO, 1'h1, 32'h3);
    nv <= 24'h20;
    bus(OFF_MODE, 1'h1, 32'h4);
    wstart;
    chk({31'h0, k < 8}, 32'h1);
    chk(shrt, 32'h1);
    wrdy;
    bus(OFF_ADC_ZS, 1'h0, 32'h0);
    chk(rd, 32'h20);
    // System calibrations on a bipolar channel, then one conversion there
    bus(OFF_STATUS, 1'h1, 32'hff);
    bus(OFF_CHSEL, 1'h1, 32'h1);
    bus(OFF_CHSET, 1'h1, 32'h4006);
    nv <= 24'h400005;
    bus(OFF_MODE, 1'h1, 32'h6);
    wstart;
    chk(chan, 32'h1);
    wrdy;
    bus(OFF_STATUS, 1'h1, 32'hff);
    nv <= 24'h200000;
    bus(OFF_MODE, 1'h1, 32'h7);
    wrdy;
    bus(OFF_STATUS, 1'h1, 32'hff);
    nv <= 24'h20;
    bus(OFF_MODE, 1'h1, 32'h2);
    wrdy;
    bus(OFF_DATA, 1'h0, 32'h0);
    chk(rd, 32'h800005);
    summarize;
  end
endmodule
